// ==== core/wfd_pkg.sv ====
// Purpose: Shared constants for the wake frame detector.
// Assumes: Registers are 16 bits wide on the management port.
// Notes: All offsets are management register addresses.

package wfd_pkg;

	// ------------------------------------------------------------
	// Register addresses
	// ------------------------------------------------------------
	localparam logic [15:0] ADDR_INTERRUPT_STATUS_ONE = 16'h0012;
	localparam logic [15:0] ADDR_WAKE_CFG = 16'h04a0;
	localparam logic [15:0] ADDR_WAKE_STAT = 16'h04a1;
	localparam logic [15:0] ADDR_PAT_INDEX = 16'h04a2;
	localparam logic [15:0] ADDR_PAT_DATA = 16'h04a3;
	localparam logic [15:0] ADDR_PAT_LEN = 16'h04a4;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int CFG_EN = 0;
	localparam int CFG_TYPE_LO = 1;
	localparam int CFG_LEVEL = 3;
	localparam int CFG_GPIO_LO = 4;
	localparam logic [15:0] CFG_RESET = 16'h0000;
	localparam logic [15:0] CFG_MASK = 16'h003f;
	localparam int STAT_MAGIC = 0;
	localparam int STAT_MAGIC_PW = 1;
	localparam int STAT_PATTERN = 2;
	localparam int STAT_CRC_DROP = 3;
	localparam int INT_WAKE_PEND = 1;
	localparam int INT_WAKE_EN = 9;
	localparam logic [6:0] PAT_LEN_RESET = 7'h40;

	// ------------------------------------------------------------
	// Wake frame types and matching constants
	// ------------------------------------------------------------
	typedef logic [1:0] wfd_type_t;
	localparam wfd_type_t TYPE_MAGIC = 2'h0;
	localparam wfd_type_t TYPE_MAGIC_PW = 2'h1;
	localparam wfd_type_t TYPE_PATTERN = 2'h2;
	localparam logic [1:0] GPIO_NONE = 2'h3;
	localparam logic [7:0] SYNC_BYTE = 8'hff;
	localparam logic [2:0] SYNC_LEN = 3'h6;
	localparam logic [2:0] ADDR_LAST_BYTE = 3'h5;
	localparam logic [6:0] MAGIC_LAST_IDX = 7'h5f;
	localparam logic [6:0] PAT_MAX = 7'h40;
	localparam logic [47:0] BCAST_ADDR = 48'hffff_ffff_ffff;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 250;
	localparam int MGMT_SETTLE_NS = 2500;
	localparam int MGMT_SETTLE_CYCLES = (MGMT_SETTLE_NS * CLK_MHZ + 999) / 1000;

endpackage

// ==== core/wfd_magic.sv ====
// Purpose: Finds the sync run, sixteen address copies and optional password.
// Assumes: frame_start comes with the first valid byte of a frame.
// Notes: found holds until the next frame start.

`timescale 1ns/10ps
`default_nettype none

module wfd_magic
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Byte stream
	input wire logic byte_valid,
	input wire logic [7:0] byte_data,
	input wire logic frame_start,
	// Match settings
	input wire logic [47:0] station_addr,
	input wire logic [47:0] password,
	input wire logic pw_en,
	// Result
	output logic found
);
	import wfd_pkg::*;

	typedef enum logic [2:0]
	{
		WFD_SYNC = 3'b001,
		WFD_ADDR = 3'b010,
		WFD_PASS = 3'b100
	} wfd_state_t;

	wfd_state_t state, next_state, st;
	logic [2:0] sync_cnt, next_sync_cnt, pos, next_pos;
	logic [6:0] idx, next_idx;
	logic next_found;

	function automatic logic [7:0] byte_of(input logic [47:0] v, input logic [2:0] i);
		case (i)
			3'h0: byte_of = v[47:40];
			3'h1: byte_of = v[39:32];
			3'h2: byte_of = v[31:24];
			3'h3: byte_of = v[23:16];
			3'h4: byte_of = v[15:8];
			default: byte_of = v[7:0];
		endcase
	endfunction

	always_comb
	begin
		st = frame_start ? WFD_SYNC : state;
		next_state = st;
		next_sync_cnt = frame_start ? 3'h0 : sync_cnt;
		next_idx = frame_start ? 7'h00 : idx;
		next_pos = frame_start ? 3'h0 : pos;
		next_found = frame_start ? 1'b0 : found;
		if (byte_valid && !next_found)
		begin
			case (st)
				WFD_SYNC:
				begin
					if (byte_data == SYNC_BYTE)
					begin
						if (next_sync_cnt != SYNC_LEN)
						begin
							next_sync_cnt = next_sync_cnt + 3'h1;
						end
					end
					else if (next_sync_cnt == SYNC_LEN && byte_data == byte_of(station_addr, 3'h0))
					begin
						next_state = WFD_ADDR;
						next_idx = 7'h01;
						next_pos = 3'h1;
					end
					else
					begin
						next_sync_cnt = 3'h0;
					end
				end
				WFD_ADDR:
				begin
					if (byte_data == byte_of(station_addr, next_pos))
					begin
						next_idx = next_idx + 7'h01;
						next_pos = (next_pos == ADDR_LAST_BYTE) ? 3'h0 : next_pos + 3'h1;
						if (next_idx == MAGIC_LAST_IDX + 7'h01)
						begin
							next_state = pw_en ? WFD_PASS : WFD_SYNC;
							next_found = !pw_en;
							next_pos = 3'h0;
							next_sync_cnt = 3'h0;
						end
					end
					else
					begin
						next_state = WFD_SYNC;
						next_sync_cnt = (byte_data == SYNC_BYTE) ? 3'h1 : 3'h0;
					end
				end
				WFD_PASS:
				begin
					if (byte_data == byte_of(password, next_pos))
					begin
						next_pos = next_pos + 3'h1;
						if (next_pos == SYNC_LEN)
						begin
							next_found = 1'b1;
							next_state = WFD_SYNC;
						end
					end
					else
					begin
						next_state = WFD_SYNC;
						next_sync_cnt = (byte_data == SYNC_BYTE) ? 3'h1 : 3'h0;
					end
				end
				default:
				begin
					next_state = WFD_SYNC;
					next_sync_cnt = 3'h0;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= WFD_SYNC;
			sync_cnt <= 3'h0;
			idx <= 7'h00;
			pos <= 3'h0;
			found <= 1'b0;
		end
		else
		begin
			state <= next_state;
			sync_cnt <= next_sync_cnt;
			idx <= next_idx;
			pos <= next_pos;
			found <= next_found;
		end
	end

	a_found_holds: assert property (@(posedge clk) disable iff (!rst_n)
		found && !frame_start |=> found)
		else $error("match flag dropped inside a frame");
	a_restart_on_ff: assert property (@(posedge clk) disable iff (!rst_n)
		state == WFD_ADDR && byte_valid && !frame_start && !found && byte_data == SYNC_BYTE
		&& byte_of(station_addr, pos) != SYNC_BYTE |=> state == WFD_SYNC && sync_cnt == 3'h1)
		else $error("breaking byte did not start a new sync run");

endmodule

`default_nettype wire

// ==== core/wfd_top.sv ====
// Purpose: Wake frame detector with management registers and pin notice.
// Assumes: rx_start marks the first byte; rx_end is a lone pulse after the last.
// Notes: Management reads answer one cycle after mgmt_rd.
//
// Operation
// - In address-repeat mode every frame addressed here is scanned for the sequence.
// - Addressed here means destination equals station address or broadcast.
// - Sequence is the station address sixteen times back to back.
// - With password enabled, password bytes must directly follow the copies.
// - Copies count only after six consecutive FF sync bytes.
// - Sync run and copies may start at any byte position.
// - Frames with a bad check sequence never raise a wake.
// - A wake gives a pulse or level change on a pin, or a flag.
// - Pattern mode compares frame bytes with up to 64 programmed bytes.
// - Three wake types: address repeat, with password, custom pattern.
// - Enables, mode and options sit in the config register at 0x04a0.
// - The wake status register at 0x04a1 tells which wake occurred.
// - Wake enable and pending flag sit in interrupt status one at 0x0012.

`timescale 1ns/10ps
`default_nettype none

module wfd_top
#(
	parameter int PULSE_CYCLES = 8
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Received frame bytes
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic rx_start,
	input wire logic rx_end,
	input wire logic rx_crc_ok,
	// Node identity
	input wire logic [47:0] station_addr,
	input wire logic [47:0] wake_password,
	// Management register port
	input wire logic [15:0] mgmt_addr,
	input wire logic [15:0] mgmt_wdata,
	input wire logic mgmt_wr,
	input wire logic mgmt_rd,
	output logic [15:0] mgmt_rdata,
	output logic mgmt_rvalid,
	// Wake notice pins
	output logic [2:0] gpio_out
);
	import wfd_pkg::*;

	logic [15:0] wake_config;
	logic [3:0] wake_status;
	logic int_en, int_pend;
	logic [7:0] pattern [0:63];
	logic [5:0] pat_index;
	logic [6:0] pat_len;
	logic [6:0] byte_cnt;
	logic dest_station, dest_bcast, pat_ok;
	logic magic_found;
	logic [7:0] pulse_cnt;
	wfd_type_t wake_type;
	logic [1:0] gpio_sel;
	logic addressed, magic_hit, pat_hit, candidate, wake_evt;
	logic rd_stat, rd_int;

	assign wake_type = wake_config[CFG_TYPE_LO +: 2];
	assign gpio_sel = wake_config[CFG_GPIO_LO +: 2];
	assign rd_stat = mgmt_rd && mgmt_addr == ADDR_WAKE_STAT;
	assign rd_int = mgmt_rd && mgmt_addr == ADDR_INTERRUPT_STATUS_ONE;

	// ------------------------------------------------------------
	// Frame tracking
	// ------------------------------------------------------------
	function automatic logic [7:0] addr_byte(input logic [47:0] v, input logic [6:0] i);
		addr_byte = v[8'(47 - 8 * int'(i)) -: 8];
	endfunction

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			byte_cnt <= 7'h00;
			dest_station <= 1'b0;
			dest_bcast <= 1'b0;
			pat_ok <= 1'b0;
		end
		else if (rx_valid)
		begin
			if (rx_start)
			begin
				byte_cnt <= 7'h01;
				dest_station <= rx_data == addr_byte(station_addr, 7'h00);
				dest_bcast <= rx_data == addr_byte(BCAST_ADDR, 7'h00);
				pat_ok <= pat_len != 7'h00 && rx_data == pattern[0];
			end
			else
			begin
				if (byte_cnt != PAT_MAX)
				begin
					byte_cnt <= byte_cnt + 7'h01;
				end
				if (byte_cnt < 7'h06)
				begin
					dest_station <= dest_station && rx_data == addr_byte(station_addr, byte_cnt);
					dest_bcast <= dest_bcast && rx_data == addr_byte(BCAST_ADDR, byte_cnt);
				end
				if (byte_cnt < pat_len && rx_data != pattern[byte_cnt[5:0]])
				begin
					pat_ok <= 1'b0;
				end
			end
		end
	end

	wfd_magic u_magic
	(
		.clk(clk),
		.rst_n(rst_n),
		.byte_valid(rx_valid),
		.byte_data(rx_data),
		.frame_start(rx_start),
		.station_addr(station_addr),
		.password(wake_password),
		.pw_en(wake_type == TYPE_MAGIC_PW),
		.found(magic_found)
	);

	// ------------------------------------------------------------
	// Wake decision
	// ------------------------------------------------------------
	assign addressed = dest_station || dest_bcast;
	assign magic_hit = (wake_type == TYPE_MAGIC || wake_type == TYPE_MAGIC_PW)
		&& addressed && magic_found;
	assign pat_hit = wake_type == TYPE_PATTERN && pat_ok && byte_cnt >= pat_len;
	assign candidate = rx_end && wake_config[CFG_EN] && (magic_hit || pat_hit);
	assign wake_evt = candidate && rx_crc_ok;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wake_status <= 4'h0;
		end
		else
		begin
			wake_status <= (rd_stat ? 4'h0 : wake_status) |
				{candidate && !rx_crc_ok, wake_evt && pat_hit,
				wake_evt && magic_hit && wake_type == TYPE_MAGIC_PW,
				wake_evt && magic_hit && wake_type == TYPE_MAGIC};
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			int_pend <= 1'b0;
		end
		else
		begin
			int_pend <= (int_pend && !rd_int) || (wake_evt && int_en);
		end
	end

	// ------------------------------------------------------------
	// Pin notice
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			gpio_out <= 3'h0;
			pulse_cnt <= 8'h00;
		end
		else if (wake_evt && gpio_sel != GPIO_NONE && wake_config[CFG_LEVEL])
		begin
			gpio_out[gpio_sel] <= !gpio_out[gpio_sel];
		end
		else if (wake_evt && gpio_sel != GPIO_NONE)
		begin
			gpio_out <= 3'h0;
			gpio_out[gpio_sel] <= 1'b1;
			pulse_cnt <= 8'(PULSE_CYCLES - 1);
		end
		else if (!wake_config[CFG_LEVEL])
		begin
			if (pulse_cnt != 8'h00)
			begin
				pulse_cnt <= pulse_cnt - 8'h01;
			end
			else
			begin
				gpio_out <= 3'h0;
			end
		end
	end

	// ------------------------------------------------------------
	// Management registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wake_config <= CFG_RESET;
			int_en <= 1'b0;
			pat_index <= 6'h00;
			pat_len <= PAT_LEN_RESET;
		end
		else if (mgmt_wr)
		begin
			case (mgmt_addr)
				ADDR_WAKE_CFG: wake_config <= mgmt_wdata & CFG_MASK;
				ADDR_INTERRUPT_STATUS_ONE: int_en <= mgmt_wdata[INT_WAKE_EN];
				ADDR_PAT_INDEX: pat_index <= mgmt_wdata[5:0];
				ADDR_PAT_DATA: pat_index <= pat_index + 6'h01;
				ADDR_PAT_LEN: pat_len <= (mgmt_wdata[6:0] > PAT_MAX) ? PAT_MAX : mgmt_wdata[6:0];
				default: pat_index <= pat_index;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (mgmt_wr && mgmt_addr == ADDR_PAT_DATA)
		begin
			pattern[pat_index] <= mgmt_wdata[7:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mgmt_rdata <= 16'h0000;
			mgmt_rvalid <= 1'b0;
		end
		else
		begin
			mgmt_rvalid <= mgmt_rd;
			mgmt_rdata <= 16'h0000;
			if (mgmt_rd)
			begin
				case (mgmt_addr)
					ADDR_WAKE_CFG: mgmt_rdata <= wake_config;
					ADDR_WAKE_STAT: mgmt_rdata <= {12'h000, wake_status};
					ADDR_INTERRUPT_STATUS_ONE: mgmt_rdata <= 16'((32'(int_en) << INT_WAKE_EN)
						| (32'(int_pend) << INT_WAKE_PEND));
					ADDR_PAT_INDEX: mgmt_rdata <= {10'h000, pat_index};
					ADDR_PAT_DATA: mgmt_rdata <= {8'h00, pattern[pat_index]};
					ADDR_PAT_LEN: mgmt_rdata <= {9'h000, pat_len};
					default: mgmt_rdata <= 16'h0000;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_pulse_start;
		wake_evt && !wake_config[CFG_LEVEL] && gpio_sel == 2'h0;
	endsequence
	sequence s_pulse_body;
		gpio_out[0] [*8];
	endsequence

	a_crc_gate: assert property (rx_end && !rx_crc_ok && !int_pend |=> !int_pend)
		else $error("bad check sequence raised a wake");
	a_crc_status: assert property (candidate && !rx_crc_ok |=> wake_status[STAT_CRC_DROP])
		else $error("dropped wake not reported");
	a_pend_set: assert property (wake_evt && int_en |=> int_pend)
		else $error("wake did not set pending flag");
	a_dest_only: assert property (rx_end && wake_type != TYPE_PATTERN && !addressed
		&& !int_pend |=> !int_pend)
		else $error("frame for another node raised a wake");
	a_stat_set_wins: assert property (wake_evt && pat_hit && rd_stat |=> wake_status[STAT_PATTERN])
		else $error("event lost under status clear");
	a_pulse_width: assert property (s_pulse_start |=> s_pulse_body ##1 !gpio_out[0])
		else $error("pulse width wrong");
	a_level_toggle: assert property (wake_evt && wake_config[CFG_LEVEL] && gpio_sel == 2'h2
		|=> gpio_out[2] != $past(gpio_out[2]))
		else $error("level did not change on wake");
	a_cfg_readback: assert property (mgmt_rd && !mgmt_wr && mgmt_addr == ADDR_WAKE_CFG
		|=> mgmt_rvalid && mgmt_rdata == $past(wake_config))
		else $error("config readback wrong");
	a_pattern_type: assert property (wake_evt && wake_type == TYPE_PATTERN
		|-> pat_ok && byte_cnt >= pat_len)
		else $error("pattern wake without full match");

endmodule

`default_nettype wire

// ==== dv/wfd_host.sv ====
// Purpose: Host side model that feeds received frames and drives the management port.
// Assumes: Requests change 1 ns after a rising clock edge.
// Notes: Released data, address and check lines show the inverse of their last value; strobes drop to 0.

`timescale 1ns/10ps
`default_nettype none

module wfd_host
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Frame stream
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic rx_start,
	output logic rx_end,
	output logic rx_crc_ok,
	// Management port
	output logic [15:0] mgmt_addr,
	output logic [15:0] mgmt_wdata,
	output logic mgmt_wr,
	output logic mgmt_rd,
	input wire logic [15:0] mgmt_rdata,
	input wire logic mgmt_rvalid,
	// Settle status
	output logic settled
);
	import wfd_pkg::*;

	logic [7:0] fq[$];
	int settle_cnt;

	initial
	begin
		{rx_valid, rx_start, rx_end, rx_crc_ok, mgmt_wr, mgmt_rd} = 6'h00;
		rx_data = 8'h00;
		mgmt_addr = 16'h0000;
		mgmt_wdata = 16'h0000;
	end

	// Management access is held off until the settle time after reset has run out.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			settle_cnt <= 0;
		else if (settle_cnt < MGMT_SETTLE_CYCLES)
			settle_cnt <= settle_cnt + 1;
	end
	assign settled = (settle_cnt >= MGMT_SETTLE_CYCLES);

	task automatic send(input logic crc);
		int i;
		for (i = 0; i < fq.size(); i++)
		begin
			@(posedge clk);
			#1;
			rx_valid = 1'b1;
			rx_start = (i == 0);
			rx_data = fq[i];
		end
		@(posedge clk);
		#1;
		rx_valid = 1'b0;
		rx_start = 1'b0;
		rx_data = ~rx_data;
		rx_end = 1'b1;
		rx_crc_ok = crc;
		@(posedge clk);
		#1;
		rx_end = 1'b0;
		rx_crc_ok = ~crc;
		fq.delete();
	endtask

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		#1;
		mgmt_wr = 1'b1;
		mgmt_addr = a;
		mgmt_wdata = d;
		@(posedge clk);
		#1;
		mgmt_wr = 1'b0;
		mgmt_addr = ~a;
		mgmt_wdata = ~d;
	endtask

	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		@(posedge clk);
		#1;
		mgmt_rd = 1'b1;
		mgmt_addr = a;
		@(posedge clk);
		#1;
		mgmt_rd = 1'b0;
		mgmt_addr = ~a;
		d = mgmt_rvalid ? mgmt_rdata : 16'hxxxx;
	endtask
endmodule

`default_nettype wire

// ==== dv/wake_frame_detector_tb.sv ====
// Purpose: Self-checking bench for the wake frame detector.
// Assumes: The pulse notice lasts PULSE_CYCLES cycles.
// Notes: Each frame sent by run carries a broken sync run and a broken copy before the real ones.

`timescale 1ns/10ps
`default_nettype none

module wake_frame_detector_tb;
	import wfd_pkg::*;

	localparam int PULSE_CYCLES = 8;
	localparam logic [47:0] STA = 48'h1122_3344_5566;
	localparam logic [47:0] PW = 48'h2a2b_2c2d_2e2f;
	localparam logic [31:0] PAT = 32'hdead_beef;

	logic clk, rst_n, rx_valid, rx_start, rx_end, rx_crc_ok, mgmt_wr, mgmt_rd, mgmt_rvalid;
	logic settled;
	logic [7:0] rx_data;
	logic [15:0] mgmt_addr, mgmt_wdata, mgmt_rdata;
	logic [2:0] gpio_out;
	int mismatches, num_checks, cycles;

	wfd_top #(.PULSE_CYCLES(PULSE_CYCLES)) i_wfd_top (.clk, .rst_n, .rx_valid, .rx_data,
		.rx_start, .rx_end, .rx_crc_ok, .station_addr(STA), .wake_password(PW), .mgmt_addr,
		.mgmt_wdata, .mgmt_wr, .mgmt_rd, .mgmt_rdata, .mgmt_rvalid, .gpio_out);
	wfd_host i_wfd_host (.clk, .rst_n, .rx_valid, .rx_data, .rx_start, .rx_end, .rx_crc_ok,
		.mgmt_addr, .mgmt_wdata, .mgmt_wr, .mgmt_rd, .mgmt_rdata, .mgmt_rvalid, .settled);

	always #2 clk = ~clk;

	task automatic results();
		$display("Checks %0d, mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			results();
		end
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] want);
		num_checks++;
		if (seen !== want)
		begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, want);
		end
	endtask

	function automatic logic [15:0] cfg(input wfd_type_t t, input logic lvl, input logic [1:0] p);
		cfg = (16'h0001 << CFG_EN) | (16'(t) << CFG_TYPE_LO) | (16'(lvl) << CFG_LEVEL)
			| (16'(p) << CFG_GPIO_LO);
	endfunction

	task automatic push48(input logic [47:0] v);
		int i;
		for (i = 5; i >= 0; i--)
			i_wfd_host.fq.push_back(v[8*i +: 8]);
	endtask

	// Sends one frame, then checks the pins and the wake status.
	task automatic run(input logic [47:0] dest, input int ncop, input logic [47:0] pw,
		input logic crc, input logic [2:0] gexp, input logic [15:0] sexp);
		int i;
		logic [15:0] d;
		push48(dest);
		push48(48'h0200_0000_0001);
		push48(48'h0800_ffff_ff00);
		push48(BCAST_ADDR);
		push48({STA[47:32], 32'hffff_ffff});
		i_wfd_host.fq.push_back(8'hff);
		i_wfd_host.fq.push_back(8'hff);
		for (i = 0; i < ncop; i++)
			push48(STA);
		push48(pw);
		push48(48'h5a5a_5a5a_5a5a);
		i_wfd_host.send(crc);
		@(posedge clk);
		#1;
		chk({13'h0000, gpio_out}, {13'h0000, gexp});
		i_wfd_host.rd(ADDR_WAKE_STAT, d);
		chk(d, sexp);
	endtask

	task automatic t_reset();
		logic [15:0] d;
		i_wfd_host.rd(ADDR_WAKE_CFG, d);
		chk(d, CFG_RESET);
		i_wfd_host.rd(ADDR_INTERRUPT_STATUS_ONE, d);
		chk(d, 16'h0000);
		i_wfd_host.rd(16'h0100, d);
		chk(d, 16'h0000);
		i_wfd_host.wr(ADDR_WAKE_CFG, 16'hffff);
		i_wfd_host.rd(ADDR_WAKE_CFG, d);
		chk(d, CFG_MASK);
	endtask

	task automatic t_plain();
		logic [15:0] d;
		i_wfd_host.wr(ADDR_INTERRUPT_STATUS_ONE, 16'h0001 << INT_WAKE_EN);
		i_wfd_host.wr(ADDR_WAKE_CFG, cfg(TYPE_MAGIC, 1'b0, 2'h0));
		run(STA, 16, PW, 1'b1, 3'b001, 16'h0001 << STAT_MAGIC);
		i_wfd_host.rd(ADDR_WAKE_STAT, d);
		chk(d, 16'h0000);
		i_wfd_host.rd(ADDR_INTERRUPT_STATUS_ONE, d);
		chk(d, (16'h0001 << INT_WAKE_EN) | (16'h0001 << INT_WAKE_PEND));
		repeat (PULSE_CYCLES) @(posedge clk);
		#1;
		chk({13'h0000, gpio_out}, 16'h0000);
		run(STA, 15, PW, 1'b1, 3'b000, 16'h0000);
		run(STA, 16, PW, 1'b0, 3'b000, 16'h0001 << STAT_CRC_DROP);
		run(48'h1122_3344_5577, 16, PW, 1'b1, 3'b000, 16'h0000);
		run(BCAST_ADDR, 16, PW, 1'b1, 3'b001, 16'h0001 << STAT_MAGIC);
	endtask

	task automatic t_pw();
		i_wfd_host.wr(ADDR_WAKE_CFG, cfg(TYPE_MAGIC_PW, 1'b0, 2'h1));
		run(STA, 16, 48'h2a2b_2c2d_2e00, 1'b1, 3'b000, 16'h0000);
		run(STA, 16, PW, 1'b1, 3'b010, 16'h0001 << STAT_MAGIC_PW);
	endtask

	task automatic t_pat();
		int i;
		logic [15:0] d;
		i_wfd_host.wr(ADDR_PAT_INDEX, 16'h0000);
		for (i = 0; i < 4; i++)
			i_wfd_host.wr(ADDR_PAT_DATA, {8'h00, PAT[31-8*i -: 8]});
		i_wfd_host.wr(ADDR_PAT_LEN, 16'h0004);
		i_wfd_host.wr(ADDR_PAT_INDEX, 16'h0002);
		i_wfd_host.rd(ADDR_PAT_DATA, d);
		chk(d, 16'h00be);
		i_wfd_host.wr(ADDR_WAKE_CFG, cfg(TYPE_PATTERN, 1'b1, 2'h2));
		run({PAT, 16'h0102}, 0, PW, 1'b1, 3'b100, 16'h0001 << STAT_PATTERN);
		repeat (PULSE_CYCLES) @(posedge clk);
		#1;
		chk({13'h0000, gpio_out}, 16'h0004);
		run({PAT[31:8], 24'h000102}, 0, PW, 1'b1, 3'b100, 16'h0000);
	endtask

	// A pattern wake that lands in the cycle of a status read must still be reported.
	task automatic t_clash();
		logic [15:0] d;
		push48({PAT, 16'h0102});
		fork
			i_wfd_host.send(1'b1);
			begin
				repeat (6) @(posedge clk);
				#1;
				i_wfd_host.rd(ADDR_WAKE_STAT, d);
			end
		join
		chk(d, 16'h0000);
		i_wfd_host.rd(ADDR_WAKE_STAT, d);
		chk(d, 16'h0001 << STAT_PATTERN);
		chk({13'h0000, gpio_out}, 16'h0000);
	endtask

	task automatic t_off();
		i_wfd_host.wr(ADDR_WAKE_CFG, CFG_RESET);
		run(STA, 16, PW, 1'b1, 3'b000, 16'h0000);
	endtask

	initial
	begin
		clk = 1'b0;
		rst_n = 1'b0;
		mismatches = 0;
		num_checks = 0;
		cycles = 0;
		repeat (2) @(posedge clk);
		#1;
		rst_n = 1'b1;
		while (!settled)
			@(posedge clk);
		t_reset();
		t_plain();
		t_pw();
		t_pat();
		t_clash();
		t_off();
		results();
	end
endmodule

`default_nettype wire
